// File: core/ea_pkg.sv
// constants of the effective address unit
package ea_pkg;
    localparam int WORD_W = 16;            // instruction unit width, bits
    localparam int ADDR_W = 24;            // internal address width
    localparam int BUS_W = 16;             // memory bus address width
    localparam int OP_HI = 15;             // operation field top bit
    localparam int OP_LO = 12;             // operation field low bit
    localparam int RN_HI = 7;              // first register field top bit
    localparam int RN_LO = 4;              // first register field low bit
    localparam int RM_HI = 3;              // second register field top bit
    localparam int RM_LO = 0;              // second register field low bit
    localparam int CC_HI = 11;             // branch condition field top bit
    localparam int CC_LO = 8;              // branch condition field low bit
    localparam int OP2_HI = 11;            // second operation field top bit
    localparam int OP2_LO = 8;             // second operation field low bit
    localparam int NREG = 8;               // number of 32-bit general registers
    localparam logic [7:0] SHORT_PAGE = 8'hff;   // upper byte for short absolute
    localparam logic [7:0] IND_PAGE = 8'h00;     // upper byte for memory indirect
    localparam logic [7:0] EXT_TOP = 8'h00;      // top byte of a 24-bit extension
    localparam logic [31:0] REG_RESET = 32'h00000000;
    // addressing modes
    typedef enum logic [3:0] {
        MODE_REG = 4'h0,     // register direct
        MODE_IND = 4'h1,     // register indirect
        MODE_DISP = 4'h2,    // indirect with displacement
        MODE_POST = 4'h3,    // post-increment
        MODE_PRE = 4'h4,     // pre-decrement
        MODE_ABS = 4'h5,     // absolute
        MODE_IMM = 4'h6,     // immediate
        MODE_PCREL = 4'h7,   // pc relative
        MODE_MIND = 4'h8     // memory indirect
    } mode_e;
    // operand size
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } size_e;
    // extension length
    typedef enum logic [1:0] {
        EXT_8 = 2'h0,
        EXT_16 = 2'h1,
        EXT_32 = 2'h2
    } ext_e;
    // instruction class, used to check legal modes
    typedef enum logic [1:0] {
        CLS_ALU = 2'h0,
        CLS_MOVE = 2'h1,
        CLS_BIT = 2'h2,
        CLS_BRANCH = 2'h3
    } class_e;
    localparam logic [3:0] BITNUM_REG_OPS = 4'h4;  // bit ops that take a register number
endpackage : ea_pkg

// File: core/ea_regfile.sv
// general register file: eight 32-bit registers
`timescale 1ns/10ps
`default_nettype none
module ea_regfile (
    // clocking
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // read ports
    input wire logic [2:0] rdSelA,
    output logic [31:0] rdDataA,
    input wire logic [2:0] rdSelB,
    output logic [31:0] rdDataB,
    // write port
    input wire logic wrEn,
    input wire logic [2:0] wrSel,
    input wire logic [31:0] wrData
);
    logic [31:0] regs_r [ea_pkg::NREG];    // register storage
    logic [31:0] regs_nxt [ea_pkg::NREG];

    // next values: one write per cycle
    always_comb begin
        for (int i = 0; i < ea_pkg::NREG; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (wrEn) begin
            regs_nxt[wrSel] = wrData;
        end
    end

    // storage, frozen while the clock enable is low
    always_ff @(posedge mclk) begin
        for (int i = 0; i < ea_pkg::NREG; i++) begin
            if (!rstn) begin
                regs_r[i] <= ea_pkg::REG_RESET;
            end else if (ce) begin
                regs_r[i] <= regs_nxt[i];
            end
        end
    end

    // reads are combinational; write data shows next cycle
    assign rdDataA = regs_r[rdSelA];
    assign rdDataB = regs_r[rdSelB];
endmodule : ea_regfile
`default_nettype wire

// File: core/cpu_effective_address_unit.sv
// instruction field split and effective address generation
`timescale 1ns/10ps
`default_nettype none
module cpu_effective_address_unit (
    // clocking
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // instruction stream, one 16-bit word per strobe
    input wire logic wordValid,
    input wire logic [15:0] instrWord,
    input wire logic firstWord,
    // decode controls from the opcode decoder
    input wire logic [3:0] addrMode,
    input wire logic [1:0] opSize,
    input wire logic [1:0] extLen,
    input wire logic [1:0] instrClass,
    input wire logic absShort,
    input wire logic bitNumFromReg,
    input wire logic [23:0] progCounter,
    // memory word read back for memory indirect mode
    input wire logic memDataValid,
    input wire logic [15:0] memData,
    // register write port from the execution unit
    input wire logic regWrEn,
    input wire logic [2:0] regWrSel,
    input wire logic [31:0] regWrData,
    // decoded fields
    output logic [3:0] operation_field,
    output logic [3:0] operation_field2,
    output logic [3:0] first_register_field,
    output logic [3:0] second_register_field,
    output logic [3:0] branch_condition_field,
    output logic condValid,
    output logic [2:0] bitNumber,
    // results
    output logic [15:0] memAddr,
    output logic [31:0] operandValue,
    output logic [15:0] branchTarget,
    output logic memReq,
    output logic resultValid,
    output logic modeError
);
    // sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,   // waiting for the first word
        ST_EXT1 = 5'b00010,   // collecting first extension word
        ST_EXT2 = 5'b00100,   // collecting second extension word
        ST_CALC = 5'b01000,   // forming the address
        ST_MIND = 5'b10000    // waiting for the indirect word
    } state_e;

    state_e state_r, state_nxt;
    logic [31:0] ext_r, ext_nxt;             // assembled extension
    logic [3:0] mode_r, mode_nxt;
    logic [1:0] size_r, size_nxt;
    logic [1:0] elen_r, elen_nxt;
    logic short_r, short_nxt;
    logic bnReg_r, bnReg_nxt;
    // output registers
    logic [15:0] memAddr_r, memAddr_nxt;
    logic [31:0] operand_r, operand_nxt;
    logic [15:0] target_r, target_nxt;
    logic memReq_r, memReq_nxt;
    logic valid_r, valid_nxt;
    logic err_r, err_nxt;
    logic [3:0] opf_r, opf_nxt;
    logic [3:0] op2_r, op2_nxt;
    logic [3:0] rnf_r, rnf_nxt;
    logic [3:0] rmf_r, rmf_nxt;
    logic [3:0] ccf_r, ccf_nxt;
    logic ccv_r, ccv_nxt;
    logic [2:0] bitn_r, bitn_nxt;
    // register file connection
    logic [31:0] rdA, rdB;
    logic rfWr;
    logic [2:0] rfSel;
    logic [31:0] rfData;

    // size to step: 1, 2 or 4 bytes
    function automatic logic [31:0] stepOf(input logic [1:0] sz);
        case (sz)
            ea_pkg::SZ_WORD: stepOf = 32'h00000002;
            ea_pkg::SZ_LONG: stepOf = 32'h00000004;
            default: stepOf = 32'h00000001;
        endcase
    endfunction : stepOf

    // 24-bit internal address cut to the 16-bit bus
    function automatic logic [15:0] toBus(input logic [23:0] a);
        toBus = a[ea_pkg::BUS_W-1:0];
    endfunction : toBus

    // legal mode check per instruction class
    function automatic logic modeOk(input logic [1:0] c, input logic [3:0] m, input logic s);
        case (c)
            ea_pkg::CLS_ALU: modeOk = (m == ea_pkg::MODE_REG) || (m == ea_pkg::MODE_IMM);
            ea_pkg::CLS_MOVE: modeOk = (m <= ea_pkg::MODE_IMM);
            ea_pkg::CLS_BIT: modeOk = (m == ea_pkg::MODE_REG) || (m == ea_pkg::MODE_IND)
                || ((m == ea_pkg::MODE_ABS) && s);
            ea_pkg::CLS_BRANCH: modeOk = (m == ea_pkg::MODE_PCREL) || (m == ea_pkg::MODE_MIND)
                || (m == ea_pkg::MODE_IND) || (m == ea_pkg::MODE_ABS);
            default: modeOk = 1'b0;
        endcase
    endfunction : modeOk

    // register direct read by operand size
    function automatic logic [31:0] regDirect(input logic [31:0] r, input logic [1:0] sz,
                                              input logic [3:0] f);
        case (sz)
            // low three bits pick register; bit 3 set picks the high word half, or for bytes the low byte
            ea_pkg::SZ_BYTE: regDirect = {24'h000000, f[3] ? r[7:0] : r[15:8]};
            ea_pkg::SZ_WORD: regDirect = {16'h0000, f[3] ? r[31:16] : r[15:0]};
            default: regDirect = r;
        endcase
    endfunction : regDirect

    // the register file
    ea_regfile u_regs (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .rdSelA(rnf_r[2:0]),
        .rdDataA(rdA),
        .rdSelB(rmf_r[2:0]),
        .rdDataB(rdB),
        .wrEn(rfWr),
        .wrSel(rfSel),
        .wrData(rfData)
    );

    // sequencer and result computation
    always_comb begin
        logic [31:0] sum;
        logic [31:0] disp;
        logic [23:0] ea;
        sum = 32'h00000000;
        disp = 32'h00000000;
        ea = 24'h000000;
        state_nxt = state_r;
        ext_nxt = ext_r;
        mode_nxt = mode_r;
        size_nxt = size_r;
        elen_nxt = elen_r;
        short_nxt = short_r;
        bnReg_nxt = bnReg_r;
        memAddr_nxt = memAddr_r;
        operand_nxt = operand_r;
        target_nxt = target_r;
        memReq_nxt = 1'b0;
        valid_nxt = 1'b0;
        err_nxt = err_r;
        opf_nxt = opf_r;
        op2_nxt = op2_r;
        rnf_nxt = rnf_r;
        rmf_nxt = rmf_r;
        ccf_nxt = ccf_r;
        ccv_nxt = ccv_r;
        bitn_nxt = bitn_r;
        rfWr = regWrEn;
        rfSel = regWrSel;
        rfData = regWrData;
        case (state_r)
            ST_IDLE: begin
                // only a whole first word starts
                if (wordValid && firstWord) begin
                    opf_nxt = instrWord[ea_pkg::OP_HI:ea_pkg::OP_LO];
                    op2_nxt = instrWord[ea_pkg::OP2_HI:ea_pkg::OP2_LO];
                    rnf_nxt = instrWord[ea_pkg::RN_HI:ea_pkg::RN_LO];
                    rmf_nxt = instrWord[ea_pkg::RM_HI:ea_pkg::RM_LO];
                    ccv_nxt = (instrClass == ea_pkg::CLS_BRANCH)
                        && (addrMode == ea_pkg::MODE_PCREL);
                    ccf_nxt = ccv_nxt ? instrWord[ea_pkg::CC_HI:ea_pkg::CC_LO] : 4'h0;
                    // bit number: register low bits or 3-bit immediate
                    bitn_nxt = instrWord[6:4];
                    mode_nxt = addrMode;
                    size_nxt = opSize;
                    elen_nxt = extLen;
                    short_nxt = absShort;
                    bnReg_nxt = bitNumFromReg;
                    ext_nxt = 32'h00000000;
                    err_nxt = !modeOk(instrClass, addrMode, absShort);
                    // short forms carry 8 bits in the first word
                    if ((addrMode == ea_pkg::MODE_ABS && absShort)
                        || addrMode == ea_pkg::MODE_MIND
                        || (addrMode == ea_pkg::MODE_PCREL && extLen == ea_pkg::EXT_8)
                        || (addrMode == ea_pkg::MODE_IMM && extLen == ea_pkg::EXT_8)) begin
                        ext_nxt = {24'h000000, instrWord[7:0]};
                        state_nxt = ST_CALC;
                    end else if (addrMode == ea_pkg::MODE_DISP || addrMode == ea_pkg::MODE_ABS
                        || addrMode == ea_pkg::MODE_IMM || addrMode == ea_pkg::MODE_PCREL) begin
                        state_nxt = ST_EXT1;
                    end else begin
                        state_nxt = ST_CALC;
                    end
                end
            end
            ST_EXT1: begin
                if (wordValid) begin
                    if (elen_r == ea_pkg::EXT_32) begin
                        ext_nxt = {instrWord, 16'h0000};
                        state_nxt = ST_EXT2;
                    end else begin
                        ext_nxt = {16'h0000, instrWord};
                        state_nxt = ST_CALC;
                    end
                end
            end
            ST_EXT2: begin
                if (wordValid) begin
                    ext_nxt = {ext_r[31:16], instrWord};
                    state_nxt = ST_CALC;
                end
            end
            ST_CALC: begin
                // bit number from a register if asked
                if (bnReg_r) begin
                    bitn_nxt = rdA[2:0];
                end
                case (mode_r)
                    ea_pkg::MODE_REG: begin
                        operand_nxt = regDirect(rdB, size_r, rmf_r);
                    end
                    ea_pkg::MODE_IND: begin
                        ea = rdA[ea_pkg::ADDR_W-1:0];
                        memReq_nxt = 1'b1;
                    end
                    ea_pkg::MODE_DISP: begin
                        // 24-bit displacement arrives with a zero top byte
                        disp = (elen_r == ea_pkg::EXT_16)
                            ? {{16{ext_r[15]}}, ext_r[15:0]}
                            : {ea_pkg::EXT_TOP, ext_r[23:0]};
                        sum = rdA + disp;
                        ea = sum[ea_pkg::ADDR_W-1:0];
                        memReq_nxt = 1'b1;
                    end
                    ea_pkg::MODE_POST: begin
                        ea = rdA[ea_pkg::ADDR_W-1:0];
                        memReq_nxt = 1'b1;
                        // full 32-bit write-back
                        rfWr = 1'b1;
                        rfSel = rnf_r[2:0];
                        rfData = rdA + stepOf(size_r);
                    end
                    ea_pkg::MODE_PRE: begin
                        sum = rdA - stepOf(size_r);
                        ea = sum[ea_pkg::ADDR_W-1:0];
                        memReq_nxt = 1'b1;
                        rfWr = 1'b1;
                        rfSel = rnf_r[2:0];
                        rfData = sum;
                    end
                    ea_pkg::MODE_ABS: begin
                        if (short_r) begin
                            ea = {ea_pkg::SHORT_PAGE, ea_pkg::SHORT_PAGE, ext_r[7:0]};
                        end else if (elen_r == ea_pkg::EXT_16) begin
                            ea = {{8{ext_r[15]}}, ext_r[15:0]};
                        end else begin
                            ea = ext_r[23:0];
                        end
                        memReq_nxt = 1'b1;
                        target_nxt = toBus(ea);
                    end
                    ea_pkg::MODE_IMM: begin
                        operand_nxt = ext_r;
                    end
                    ea_pkg::MODE_PCREL: begin
                        disp = (elen_r == ea_pkg::EXT_8)
                            ? {{24{ext_r[7]}}, ext_r[7:0]}
                            : {{16{ext_r[15]}}, ext_r[15:0]};
                        sum = {8'h00, progCounter} + disp;
                        ea = sum[ea_pkg::ADDR_W-1:0];
                        target_nxt = toBus(ea);
                    end
                    ea_pkg::MODE_MIND: begin
                        ea = {ea_pkg::IND_PAGE, ea_pkg::IND_PAGE, ext_r[7:0]};
                        memReq_nxt = 1'b1;
                    end
                    default: begin
                        err_nxt = 1'b1;
                    end
                endcase
                memAddr_nxt = toBus(ea);
                if (err_r) begin
                    memReq_nxt = 1'b0;
                    rfWr = regWrEn;
                    rfSel = regWrSel;
                    rfData = regWrData;
                end
                if (mode_r == ea_pkg::MODE_MIND && !err_r) begin
                    state_nxt = ST_MIND;
                end else begin
                    valid_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_MIND: begin
                // page-zero word is the target
                if (memDataValid) begin
                    target_nxt = memData;
                    valid_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // sequencer and output registers, frozen while ce is low
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            ext_r <= 32'h00000000;
            mode_r <= 4'h0;
            size_r <= 2'h0;
            elen_r <= 2'h0;
            short_r <= 1'b0;
            bnReg_r <= 1'b0;
            memAddr_r <= 16'h0000;
            operand_r <= 32'h00000000;
            target_r <= 16'h0000;
            memReq_r <= 1'b0;
            valid_r <= 1'b0;
            err_r <= 1'b0;
            opf_r <= 4'h0;
            op2_r <= 4'h0;
            rnf_r <= 4'h0;
            rmf_r <= 4'h0;
            ccf_r <= 4'h0;
            ccv_r <= 1'b0;
            bitn_r <= 3'h0;
        end else if (ce) begin
            state_r <= state_nxt;
            ext_r <= ext_nxt;
            mode_r <= mode_nxt;
            size_r <= size_nxt;
            elen_r <= elen_nxt;
            short_r <= short_nxt;
            bnReg_r <= bnReg_nxt;
            memAddr_r <= memAddr_nxt;
            operand_r <= operand_nxt;
            target_r <= target_nxt;
            memReq_r <= memReq_nxt;
            valid_r <= valid_nxt;
            err_r <= err_nxt;
            opf_r <= opf_nxt;
            op2_r <= op2_nxt;
            rnf_r <= rnf_nxt;
            rmf_r <= rmf_nxt;
            ccf_r <= ccf_nxt;
            ccv_r <= ccv_nxt;
            bitn_r <= bitn_nxt;
        end
    end

    // outputs straight from flip-flops
    assign operation_field = opf_r;
    assign operation_field2 = op2_r;
    assign first_register_field = rnf_r;
    assign second_register_field = rmf_r;
    assign branch_condition_field = ccf_r;
    assign condValid = ccv_r;
    assign bitNumber = bitn_r;
    assign memAddr = memAddr_r;
    assign operandValue = operand_r;
    assign branchTarget = target_r;
    assign memReq = memReq_r;
    assign resultValid = valid_r;
    assign modeError = err_r;
endmodule : cpu_effective_address_unit
`default_nettype wire

// File: tb/ea_unit_asserts.sv
// port-level checks for the effective address unit
`timescale 1ns/10ps
`default_nettype none
module ea_unit_asserts (
    // clocking
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // instruction side
    input wire logic wordValid,
    input wire logic firstWord,
    input wire logic [15:0] instrWord,
    input wire logic [3:0] addrMode,
    input wire logic absShort,
    input wire logic memDataValid,
    // results
    input wire logic memReq,
    input wire logic resultValid,
    input wire logic modeError,
    input wire logic condValid,
    input wire logic [15:0] memAddr,
    input wire logic [3:0] operation_field,
    input wire logic [3:0] branch_condition_field
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [15:0] lastWord_r, lastWord_nxt; // first word of the instruction
    logic [3:0] lastMode_r, lastMode_nxt; // its addressing mode
    logic lastShort_r, lastShort_nxt; // short absolute form
    always_comb begin
        lastWord_nxt = lastWord_r;
        lastMode_nxt = lastMode_r;
        lastShort_nxt = lastShort_r;
        if (ce && wordValid && firstWord) begin
            lastWord_nxt = instrWord;
            lastMode_nxt = addrMode;
            lastShort_nxt = absShort;
        end
    end
    always_ff @(posedge mclk) begin
        lastWord_r <= rstn ? lastWord_nxt : 16'h0000;
        lastMode_r <= rstn ? lastMode_nxt : 4'h0;
        lastShort_r <= rstn ? lastShort_nxt : 1'b0;
    end
    AST_RESULT_PULSE: assert property (resultValid |=> !resultValid)
        else $error("result strobe too long");
    AST_REQ_PULSE: assert property (memReq |=> !memReq)
        else $error("bus request too long");
    AST_ERR_NO_REQ: assert property (modeError |-> !memReq)
        else $error("request on illegal mode");
    AST_COND_ZERO: assert property (!condValid |-> branch_condition_field == 4'h0)
        else $error("condition field outside branch");
    AST_RESULT_CAUSE: assert property (resultValid && !$past(memDataValid, 1)
        |-> $past(wordValid, 2))
        else $error("result without a recent word");
    AST_SHORT_PAGE: assert property (memReq && lastMode_r == 4'h5 && lastShort_r
        |-> memAddr == {8'hff, lastWord_r[7:0]})
        else $error("short absolute off top page");
    AST_MIND_PAGE: assert property (memReq && lastMode_r == 4'h8
        |-> memAddr == {8'h00, lastWord_r[7:0]})
        else $error("indirect pointer off page zero");
    AST_OP_FIELD: assert property (resultValid |-> operation_field == lastWord_r[15:12])
        else $error("operation field wrong");
    cover property (memReq && lastMode_r == 4'h8);
    cover property (condValid && resultValid);
    cover property (modeError && resultValid);
endmodule : ea_unit_asserts
bind cpu_effective_address_unit ea_unit_asserts u_chk (.mclk, .rstn, .ce, .wordValid,
    .firstWord, .instrWord, .addrMode, .absShort, .memDataValid, .memReq, .resultValid,
    .modeError, .condValid, .memAddr, .operation_field, .branch_condition_field);
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the effective address unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic mclk, rstn, ce, wordValid, firstWord, absShort, bitNumFromReg, memDataValid, regWrEn;
    logic [15:0] instrWord, memData, memAddr, branchTarget;
    logic [3:0] addrMode, opF, op2F, rnF, rmF, ccF;
    logic [1:0] opSize, extLen, instrClass;
    logic [23:0] progCounter;
    logic [2:0] regWrSel, bitNumber;
    logic [31:0] regWrData, operandValue;
    logic condValid, memReq, resultValid, modeError;
    int n_errors, num_checks;
    cpu_effective_address_unit DUT (.mclk, .rstn, .ce, .wordValid, .instrWord, .firstWord,
        .addrMode, .opSize, .extLen, .instrClass, .absShort, .bitNumFromReg, .progCounter,
        .memDataValid, .memData, .regWrEn, .regWrSel, .regWrData, .operation_field(opF),
        .operation_field2(op2F), .first_register_field(rnF), .second_register_field(rmF),
        .branch_condition_field(ccF), .condValid, .bitNumber, .memAddr, .operandValue,
        .branchTarget, .memReq, .resultValid, .modeError);
    // counts and verdict, single exit
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // four-state compare, an unknown matches only the same unknown
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait for request or result
    task automatic waitOn(input bit req);
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge mclk);
            if ((req ? memReq : resultValid) === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
    endtask : waitOn
    // external register write, one cycle
    task automatic wrReg(input logic [2:0] s, input logic [31:0] d);
        @(negedge mclk);
        regWrEn = 1'b1;
        regWrSel = s;
        regWrData = d;
        @(negedge mclk);
        regWrEn = 1'b0;
    endtask : wrReg
    // one instruction, extension words high half first
    task automatic run(input logic [1:0] cls, input logic [3:0] md, input logic [1:0] sz,
        input logic [1:0] el, input logic [15:0] w0, input logic [31:0] ex, input int nEx,
        input bit req);
        @(negedge mclk);
        {instrClass, addrMode, opSize, extLen} = {cls, md, sz, el};
        instrWord = w0;
        wordValid = 1'b1;
        firstWord = 1'b1;
        for (int k = nEx; k > 0; k--) begin
            @(negedge mclk);
            firstWord = 1'b0;
            instrWord = ex[16*k-1 -: 16];
        end
        @(negedge mclk);
        wordValid = 1'b0;
        firstWord = 1'b0;
        instrWord = ~instrWord;
        waitOn(req);
    endtask : run
    // fields, indirect and displacement arithmetic
    task automatic scnIndirect;
        wrReg(3'h1, 32'h12345678);
        run(2'h1, 4'h1, 2'h0, 2'h0, 16'ha591, 32'h0, 0, 1);
        chk(memAddr, 16'h5678);
        chk({opF, op2F, rnF, rmF}, 16'ha591);
        run(2'h1, 4'h2, 2'h0, 2'h1, 16'ha591, 32'hfff0, 1, 1);
        chk(memAddr, 16'h5668);
        run(2'h1, 4'h2, 2'h0, 2'h2, 16'ha591, 32'h00010010, 2, 1);
        chk(memAddr, 16'h5688);
    endtask : scnIndirect
    // post-increment up by 4,2,1 then pre-decrement back by 1,2,4
    task automatic scnAutoStep;
        logic [15:0] a;
        a = 16'h0100;
        wrReg(3'h2, 32'h00000100);
        for (int s = 2; s >= 0; s--) begin
            run(2'h1, 4'h3, s[1:0], 2'h0, 16'h1020, 32'h0, 0, 1);
            chk(memAddr, a);
            a = a + (16'h0001 << s);
        end
        for (int s = 0; s < 3; s++) begin
            a = a - (16'h0001 << s);
            run(2'h1, 4'h4, s[1:0], 2'h0, 16'h1020, 32'h0, 0, 1);
            chk(memAddr, a);
        end
    endtask : scnAutoStep
    // absolute forms and immediates
    task automatic scnAbsImm;
        absShort = 1'b1;
        run(2'h1, 4'h5, 2'h0, 2'h0, 16'h1034, 32'h0, 0, 1);
        chk(memAddr, 16'hff34);
        absShort = 1'b0;
        run(2'h1, 4'h5, 2'h1, 2'h1, 16'h1000, 32'h8001, 1, 1);
        chk(memAddr, 16'h8001);
        run(2'h1, 4'h5, 2'h0, 2'h2, 16'h1000, 32'h00abcdef, 2, 1);
        chk(memAddr, 16'hcdef);
        run(2'h0, 4'h6, 2'h2, 2'h2, 16'h1000, 32'hdeadbeef, 2, 0);
        chk(operandValue, 32'hdeadbeef);
    endtask : scnAbsImm
    // register halves by size, and bit numbers
    task automatic scnRegBit;
        logic [3:0] rm [5] = '{4'hb, 4'h3, 4'hb, 4'h3, 4'h3};
        logic [1:0] sz [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
        logic [31:0] ex [5] = '{32'h44, 32'h33, 32'h1122, 32'h3344, 32'h11223344};
        wrReg(3'h3, 32'h11223344);
        for (int i = 0; i < 5; i++) begin
            run(2'h0, 4'h0, sz[i], 2'h0, {12'h100, rm[i]}, 32'h0, 0, 0);
            chk(operandValue & ~(32'hffffffff << (8 << sz[i])), ex[i]);
        end
        run(2'h2, 4'h0, 2'h0, 2'h0, 16'h1053, 32'h0, 0, 0);
        chk(bitNumber, 3'h5);
        bitNumFromReg = 1'b1;
        run(2'h2, 4'h0, 2'h0, 2'h0, 16'h1033, 32'h0, 0, 0);
        chk(bitNumber, 3'h4);
        bitNumFromReg = 1'b0;
    endtask : scnRegBit
    // relative branches, memory indirect, condition field
    task automatic scnBranch;
        progCounter = 24'h001000;
        run(2'h3, 4'h7, 2'h0, 2'h0, 16'h45fe, 32'h0, 0, 0);
        chk({branchTarget, condValid, ccF}, {16'h0ffe, 1'b1, 4'h5});
        run(2'h3, 4'h7, 2'h0, 2'h1, 16'h4500, 32'h8000, 1, 0);
        chk(branchTarget, 16'h9000);
        run(2'h3, 4'h8, 2'h0, 2'h0, 16'h5020, 32'h0, 0, 1);
        chk(memAddr, 16'h0020);
        memDataValid = 1'b1;
        memData = 16'habcd;
        waitOn(0);
        memDataValid = 1'b0;
        chk({branchTarget, condValid, ccF}, {16'habcd, 1'b0, 4'h0});
    endtask : scnBranch
    // illegal modes per class
    task automatic scnIllegal;
        logic [3:0] md [7] = '{4'h1, 4'h3, 4'h4, 4'h7, 4'h8, 4'h0, 4'h6};
        for (int i = 0; i < 7; i++) begin
            run(2'h0, md[i], 2'h0, 2'h0, 16'h1000, 32'h0, 0, 0);
            chk({modeError, memReq}, {i < 5, 1'b0});
        end
        run(2'h2, 4'h7, 2'h0, 2'h0, 16'h1000, 32'h0, 0, 0);
        chk(modeError, 1'b1);
    endtask : scnIllegal
    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // reset, then the scenarios
    initial begin
        {rstn, wordValid, firstWord, absShort, bitNumFromReg, memDataValid, regWrEn} = 7'h00;
        ce = 1'b1;
        {instrWord, memData, addrMode, opSize, extLen, instrClass} = 42'h0;
        {progCounter, regWrSel, regWrData} = 59'h0;
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        chk({memAddr, memReq, resultValid}, 18'h0);
        scnIndirect();
        scnAutoStep();
        scnAbsImm();
        scnRegBit();
        scnBranch();
        scnIllegal();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
